// ===== common/sfm_pkg.sv
// package for the special function register bank with boot-zone select
package sfm_pkg;
   localparam logic [7:0] ADR_PORT0 = 8'h80;
   localparam logic [7:0] ADR_SP = 8'h81;
   localparam logic [7:0] ADR_DPL = 8'h82;
   localparam logic [7:0] ADR_DPH = 8'h83;
   localparam logic [7:0] ADR_XRAMPG = 8'h85;
   localparam logic [7:0] ADR_DATA_BANK_SELECT = 8'h86;
   localparam logic [7:0] ADR_PWRCTL = 8'h87;
   localparam logic [7:0] ADR_TCTL = 8'h88;
   localparam logic [7:0] ADR_TMODE = 8'h89;
   localparam logic [7:0] ADR_T0L = 8'h8a;
   localparam logic [7:0] ADR_T1L = 8'h8b;
   localparam logic [7:0] ADR_T0H = 8'h8c;
   localparam logic [7:0] ADR_T1H = 8'h8d;
   localparam logic [7:0] ADR_PORT1 = 8'h90;
   localparam logic [7:0] ADR_SCTL = 8'h98;
   localparam logic [7:0] ADR_SERIAL_BUFFER = 8'h99;
   localparam logic [7:0] ADR_PWMEN = 8'h9b;
   localparam logic [7:0] ADR_WDCTL = 8'h9f;
   localparam logic [7:0] ADR_PORT2 = 8'ha0;
   localparam logic [7:0] ADR_PWMCK = 8'ha3;
   localparam logic [7:0] ADR_PWM0 = 8'ha4;
   localparam logic [7:0] ADR_PWM1 = 8'ha5;
   localparam logic [7:0] ADR_PWM2 = 8'ha6;
   localparam logic [7:0] ADR_PWM3 = 8'ha7;
   localparam logic [7:0] ADR_PWM4 = 8'hac;
   localparam logic [7:0] ADR_IEN = 8'ha8;
   localparam logic [7:0] ADR_PORT3 = 8'hb0;
   localparam logic [7:0] ADR_IPRI = 8'hb8;
   localparam logic [7:0] ADR_SYSCFG = 8'hbf;
   localparam logic [7:0] ADR_T2CTL = 8'hc8;
   localparam logic [7:0] ADR_T2RL = 8'hca;
   localparam logic [7:0] ADR_T2RH = 8'hcb;
   localparam logic [7:0] ADR_T2L = 8'hcc;
   localparam logic [7:0] ADR_T2H = 8'hcd;
   localparam logic [7:0] ADR_STATW = 8'hd0;
   localparam logic [7:0] ADR_PORT4 = 8'hd8;
   localparam logic [7:0] ADR_ACCUM = 8'he0;
   localparam logic [7:0] ADR_MULB = 8'hf0;
   localparam logic [7:0] ADR_SPAH = 8'hf4;
   localparam logic [7:0] ADR_SPAL = 8'hf5;
   localparam logic [7:0] ADR_SPDAT = 8'hf6;
   localparam logic [7:0] ADR_SPCTL = 8'hf7;
   localparam logic [7:0] RST_PORT = 8'hff;
   localparam logic [7:0] RST_PORT3 = 8'hfb;
   localparam logic [3:0] RST_PORT4 = 4'hf;
   localparam logic [7:0] RST_SP = 8'h07;
   localparam logic [7:0] RST_SERIAL_BUFFER = 8'h7f;
   localparam logic [7:0] RST_SYSCFG = 8'h0a;
   localparam logic [7:0] RST_DATA_BANK_SELECT = 8'h01;
   localparam logic [7:0] RST_TCTL = 8'h02;
   localparam logic [7:0] RST_STATW = 8'h01;
   localparam logic [7:0] RST_ZERO = 8'h00;
   // writable bit masks
   localparam logic [7:0] MSK_SYSCFG = 8'h87;
   localparam logic [7:0] MSK_DATA_BANK_SELECT = 8'h8f;
   localparam logic [7:0] MSK_PWRCTL = 8'h8f;
   localparam logic [7:0] MSK_WDCTL = 8'ha7;
   localparam logic [7:0] MSK_XRAMPG = 8'h03;
   localparam logic [7:0] MSK_PWMEN = 8'hf8;
   localparam logic [7:0] MSK_PWMCK = 8'h03;
   localparam logic [7:0] MSK_IEN = 8'hbf;
   localparam logic [7:0] MSK_IPRI = 8'h3f;
   localparam logic [7:0] MSK_STATW = 8'hfd;
   localparam logic [7:0] MSK_SPCTL = 8'h83;
   localparam int SPCTL_GO_BIT = 7;
   localparam int SYSCFG_WDR_BIT = 7;
   localparam int SYSCFG_SPE_BIT = 2;
   // unlock sequence bytes
   localparam logic [7:0] UNLOCK_A = 8'h55;
   localparam logic [7:0] UNLOCK_B = 8'haa;
   // flash and boot zone
   localparam logic [7:0] BLANK_BYTE = 8'hff;
   localparam logic [15:0] RESET_VECTOR = 16'h0000;
   localparam int ZONE_STEP_BYTES = 512;
   localparam int FLASH_BYTES = 65536;
   typedef enum logic [1:0]
   {
      FN_BYTE_PROG = 2'h0,
      FN_ERASE_PROT = 2'h1,
      FN_PAGE_ERASE = 2'h2,
      FN_FULL_ERASE = 2'h3
   } sfm_func_t;
   typedef enum logic [3:0]
   {
      ST_IDLE = 4'h1,
      ST_GOT1 = 4'h2,
      ST_GOT2 = 4'h4,
      ST_OPEN = 4'h8
   } sfm_unlk_t;
   // core-side access bundle
   typedef struct packed
   {
      logic wr;
      logic rd;
      logic direct;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfm_acc_t;
   // request to the flash programming engine
   typedef struct packed
   {
      logic go;
      sfm_func_t func;
      logic [15:0] addr;
      logic [7:0] data;
   } sfm_freq_t;
endpackage

// ===== core/sfm_bank.sv
// special function register bank with self-programming unlock and boot-zone start select
//
// How it works
// RULE1: only direct accesses reach registers 80h to FFh; indirect ones are dropped.
// RULE2: port latches 80h, 90h, A0h reset all ones; B0h resets with bit 2 clear.
// RULE3: port latch D8h keeps only bits 3 to 0, reset to ones.
// RULE4: serial buffer resets to 7Fh.
// RULE5: system config holds watchdog flag, prog enable, xram enable, strobe inhibit; resets 0Ah.
// RULE6: data bank register has enable in bit 7, bank number bits 3 to 0, reset 01h.
// RULE7: power control has baud doubler, two flags, power-off and sleep; resets zero.
// RULE8: watchdog control has run, clear and 3-bit prescaler; resets zero.
// RULE9: five PWM registers hold duty in 7..3 and count in 2..0; reset zero.
// RULE10: self-programming address, data and control registers, all reset zero.
// RULE11: flash is 64KB, program memory and data storage through self-programming.
// RULE12: top flash region can be a boot zone, 512 bytes to 4K in 512 steps.
// RULE13: boot code may program flash through the self-programming engine.
// RULE14: the external programmer sets the zone size; the running program cannot.
// RULE15: the external programmer should set the lock option with boot code.
// RULE16: an external programmer erase clears the whole flash including boot zone.
// RULE17: on reset with nonzero zone and blank byte 0000h, start at zone base; the code tests zone_enable instead of a nonzero zone setting.
// RULE18: zone setting zero disables the boot jump and starts normally; the code uses zone_enable low instead, setting zero gives 512 bytes.
// RULE19: stack pointer resets 07h; status word resets with only parity set.
// RULE20: start bit is read-only until 55h, AAh, 55h written to data register.
// RULE21: function code: 00 byte program, 01 protect, 10 page erase, 11 full erase.
// RULE22: unused bits read zero and ignore writes; system config bit 3 resets to one from 0Ah and keeps it.
`timescale 1ns/1ps
module sfm_bank #(
   parameter int ADDR_W = 16
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // core access, same clock
   input wire sfm_pkg::sfm_acc_t acc,
   output logic [7:0] rdata,
   // peripheral events, same clock
   input wire logic wdt_reset_event,
   input wire logic parity_in,
   // boot-zone configuration from nonvolatile fuses, static after programming
   input wire logic [2:0] zone_cfg,
   input wire logic zone_enable,
   input wire logic [7:0] flash_byte0,
   // flash programming engine, same clock
   input wire logic prog_done,
   output sfm_pkg::sfm_freq_t prog_req,
   output logic core_hold,
   // reset start address to the core
   output logic [ADDR_W-1:0] start_addr,
   output logic start_valid,
   // control bits to other blocks
   output logic [7:0] sys_cfg,
   output logic [7:0] pwr_ctl,
   output logic [7:0] wdt_ctl,
   output logic [7:0] bank_sel
);

////////////////////////////////////////////////////////////////////////////////
   typedef struct packed
   {
      logic [7:0] p0, sp, data_pointer_low, data_pointer_high, xpg, data_bank_select, pwr, tctl, timer_mode, t0l, t1l, t0h, t1h;
      logic [7:0] p1, sctl, serial_buffer, pwmen, wdt, p2, pwmck, ien, p3, ipri, syscfg;
      logic [7:0] t2c, t2rl, t2rh, t2l, t2h, processor_status_word, acc, mulb, spah, spal, spdat, spctl;
      logic [39:0] pwm;
      logic [3:0] p4;
      sfm_pkg::sfm_unlk_t unlk;
      logic [7:0] rdata;
      logic [ADDR_W-1:0] start;
      logic start_vld;
      logic started;
      sfm_pkg::sfm_freq_t req;
   } st_t;

   st_t s_q, s_d;

   // boot zone base: top of flash less (cfg+1) steps of 512 bytes
   function automatic logic [ADDR_W-1:0] zone_base(input logic [2:0] cfg);
      logic [ADDR_W:0] sz;
      sz = (ADDR_W+1)'(({1'b0, cfg} + 4'h1) * sfm_pkg::ZONE_STEP_BYTES);
      zone_base = ADDR_W'((ADDR_W+1)'(sfm_pkg::FLASH_BYTES) - sz); // [RULE12]
   endfunction

   function automatic logic [7:0] mw(input logic [7:0] old, input logic [7:0] nw, input logic [7:0] m);
      mw = (old & ~m) | (nw & m);
   endfunction

   logic sel;
   logic [7:0] rd_v;
   logic start_ok;

   always_comb
   begin
      s_d = s_q;
      sel = acc.direct & acc.addr[7]; // [RULE1]
      // read mux; unused bits come back zero through the masks, except SYSCFG bit 3, which reads its reset one
      unique case (acc.addr)
         sfm_pkg::ADR_PORT0: rd_v = s_q.p0;
         sfm_pkg::ADR_SP: rd_v = s_q.sp;
         sfm_pkg::ADR_DPL: rd_v = s_q.data_pointer_low;
         sfm_pkg::ADR_DPH: rd_v = s_q.data_pointer_high;
         sfm_pkg::ADR_XRAMPG: rd_v = s_q.xpg;
         sfm_pkg::ADR_DATA_BANK_SELECT: rd_v = s_q.data_bank_select;
         sfm_pkg::ADR_PWRCTL: rd_v = s_q.pwr;
         sfm_pkg::ADR_TCTL: rd_v = s_q.tctl;
         sfm_pkg::ADR_TMODE: rd_v = s_q.timer_mode;
         sfm_pkg::ADR_T0L: rd_v = s_q.t0l;
         sfm_pkg::ADR_T1L: rd_v = s_q.t1l;
         sfm_pkg::ADR_T0H: rd_v = s_q.t0h;
         sfm_pkg::ADR_T1H: rd_v = s_q.t1h;
         sfm_pkg::ADR_PORT1: rd_v = s_q.p1;
         sfm_pkg::ADR_SCTL: rd_v = s_q.sctl;
         sfm_pkg::ADR_SERIAL_BUFFER: rd_v = s_q.serial_buffer;
         sfm_pkg::ADR_PWMEN: rd_v = s_q.pwmen;
         sfm_pkg::ADR_WDCTL: rd_v = s_q.wdt;
         sfm_pkg::ADR_PORT2: rd_v = s_q.p2;
         sfm_pkg::ADR_PWMCK: rd_v = s_q.pwmck;
         sfm_pkg::ADR_PWM0: rd_v = s_q.pwm[7:0];
         sfm_pkg::ADR_PWM1: rd_v = s_q.pwm[15:8];
         sfm_pkg::ADR_PWM2: rd_v = s_q.pwm[23:16];
         sfm_pkg::ADR_PWM3: rd_v = s_q.pwm[31:24];
         sfm_pkg::ADR_PWM4: rd_v = s_q.pwm[39:32];
         sfm_pkg::ADR_IEN: rd_v = s_q.ien;
         sfm_pkg::ADR_PORT3: rd_v = s_q.p3;
         sfm_pkg::ADR_IPRI: rd_v = s_q.ipri;
         sfm_pkg::ADR_SYSCFG: rd_v = s_q.syscfg;
         sfm_pkg::ADR_T2CTL: rd_v = s_q.t2c;
         sfm_pkg::ADR_T2RL: rd_v = s_q.t2rl;
         sfm_pkg::ADR_T2RH: rd_v = s_q.t2rh;
         sfm_pkg::ADR_T2L: rd_v = s_q.t2l;
         sfm_pkg::ADR_T2H: rd_v = s_q.t2h;
         sfm_pkg::ADR_STATW: rd_v = s_q.processor_status_word;
         sfm_pkg::ADR_PORT4: rd_v = {4'h0, s_q.p4}; // [RULE3]
         sfm_pkg::ADR_ACCUM: rd_v = s_q.acc;
         sfm_pkg::ADR_MULB: rd_v = s_q.mulb;
         sfm_pkg::ADR_SPAH: rd_v = s_q.spah;
         sfm_pkg::ADR_SPAL: rd_v = s_q.spal;
         sfm_pkg::ADR_SPDAT: rd_v = s_q.spdat;
         sfm_pkg::ADR_SPCTL: rd_v = s_q.spctl;
         default: rd_v = 8'h00; // [RULE22]
      endcase
      s_d.rdata = (acc.rd & sel) ? rd_v : 8'h00; // [RULE1]

      // writes; masks keep unused bits at zero, except SYSCFG bit 3, which keeps its reset one
      if (acc.wr & sel)
      begin
         unique case (acc.addr)
            sfm_pkg::ADR_PORT0: s_d.p0 = acc.wdata;
            sfm_pkg::ADR_SP: s_d.sp = acc.wdata;
            sfm_pkg::ADR_DPL: s_d.data_pointer_low = acc.wdata;
            sfm_pkg::ADR_DPH: s_d.data_pointer_high = acc.wdata;
            sfm_pkg::ADR_XRAMPG: s_d.xpg = acc.wdata & sfm_pkg::MSK_XRAMPG;
            sfm_pkg::ADR_DATA_BANK_SELECT: s_d.data_bank_select = acc.wdata & sfm_pkg::MSK_DATA_BANK_SELECT; // [RULE6]
            sfm_pkg::ADR_PWRCTL: s_d.pwr = acc.wdata & sfm_pkg::MSK_PWRCTL; // [RULE7]
            sfm_pkg::ADR_TCTL: s_d.tctl = acc.wdata;
            sfm_pkg::ADR_TMODE: s_d.timer_mode = acc.wdata;
            sfm_pkg::ADR_T0L: s_d.t0l = acc.wdata;
            sfm_pkg::ADR_T1L: s_d.t1l = acc.wdata;
            sfm_pkg::ADR_T0H: s_d.t0h = acc.wdata;
            sfm_pkg::ADR_T1H: s_d.t1h = acc.wdata;
            sfm_pkg::ADR_PORT1: s_d.p1 = acc.wdata;
            sfm_pkg::ADR_SCTL: s_d.sctl = acc.wdata;
            sfm_pkg::ADR_SERIAL_BUFFER: s_d.serial_buffer = acc.wdata;
            sfm_pkg::ADR_PWMEN: s_d.pwmen = acc.wdata & sfm_pkg::MSK_PWMEN;
            sfm_pkg::ADR_WDCTL: s_d.wdt = acc.wdata & sfm_pkg::MSK_WDCTL; // [RULE8]
            sfm_pkg::ADR_PORT2: s_d.p2 = acc.wdata;
            sfm_pkg::ADR_PWMCK: s_d.pwmck = acc.wdata & sfm_pkg::MSK_PWMCK;
            sfm_pkg::ADR_PWM0: s_d.pwm[7:0] = acc.wdata; // [RULE9]
            sfm_pkg::ADR_PWM1: s_d.pwm[15:8] = acc.wdata;
            sfm_pkg::ADR_PWM2: s_d.pwm[23:16] = acc.wdata;
            sfm_pkg::ADR_PWM3: s_d.pwm[31:24] = acc.wdata;
            sfm_pkg::ADR_PWM4: s_d.pwm[39:32] = acc.wdata;
            sfm_pkg::ADR_IEN: s_d.ien = acc.wdata & sfm_pkg::MSK_IEN;
            sfm_pkg::ADR_PORT3: s_d.p3 = acc.wdata;
            sfm_pkg::ADR_IPRI: s_d.ipri = acc.wdata & sfm_pkg::MSK_IPRI;
            // watchdog flag is hardware-set, software may clear it
            sfm_pkg::ADR_SYSCFG: s_d.syscfg = mw(s_q.syscfg, acc.wdata, sfm_pkg::MSK_SYSCFG); // [RULE5]
            sfm_pkg::ADR_T2CTL: s_d.t2c = acc.wdata;
            sfm_pkg::ADR_T2RL: s_d.t2rl = acc.wdata;
            sfm_pkg::ADR_T2RH: s_d.t2rh = acc.wdata;
            sfm_pkg::ADR_T2L: s_d.t2l = acc.wdata;
            sfm_pkg::ADR_T2H: s_d.t2h = acc.wdata;
            sfm_pkg::ADR_STATW: s_d.processor_status_word = acc.wdata & sfm_pkg::MSK_STATW;
            sfm_pkg::ADR_PORT4: s_d.p4 = acc.wdata[3:0]; // [RULE3]
            sfm_pkg::ADR_ACCUM: s_d.acc = acc.wdata;
            sfm_pkg::ADR_MULB: s_d.mulb = acc.wdata;
            sfm_pkg::ADR_SPAH: s_d.spah = acc.wdata; // [RULE10]
            sfm_pkg::ADR_SPAL: s_d.spal = acc.wdata;
            sfm_pkg::ADR_SPDAT: s_d.spdat = acc.wdata;
            sfm_pkg::ADR_SPCTL:
            begin
               // start bit only settable after unlock; function code always writable
               s_d.spctl[1:0] = acc.wdata[1:0]; // [RULE21]
               if (s_q.unlk == sfm_pkg::ST_OPEN && !s_q.spctl[sfm_pkg::SPCTL_GO_BIT])
                  s_d.spctl[sfm_pkg::SPCTL_GO_BIT] = acc.wdata[sfm_pkg::SPCTL_GO_BIT]; // [RULE20]
            end
            default: ;
         endcase
      end

      // parity is computed by the core; keep it live in bit 0
      s_d.processor_status_word[0] = parity_in; // [RULE19]

      // unlock sequence on data register writes
      if (acc.wr & sel & (acc.addr == sfm_pkg::ADR_SPDAT))
      begin
         unique case (s_q.unlk)
            sfm_pkg::ST_IDLE: s_d.unlk = (acc.wdata == sfm_pkg::UNLOCK_A) ? sfm_pkg::ST_GOT1 : sfm_pkg::ST_IDLE;
            sfm_pkg::ST_GOT1: s_d.unlk = (acc.wdata == sfm_pkg::UNLOCK_B) ? sfm_pkg::ST_GOT2 : sfm_pkg::ST_IDLE;
            sfm_pkg::ST_GOT2: s_d.unlk = (acc.wdata == sfm_pkg::UNLOCK_A) ? sfm_pkg::ST_OPEN : sfm_pkg::ST_IDLE;
            sfm_pkg::ST_OPEN: s_d.unlk = sfm_pkg::ST_OPEN;
            default: s_d.unlk = sfm_pkg::ST_IDLE;
         endcase
      end

      // operation done: clear start bit and relock; a fresh unlock is needed
      if (s_q.spctl[sfm_pkg::SPCTL_GO_BIT] & prog_done)
      begin
         s_d.spctl[sfm_pkg::SPCTL_GO_BIT] = 1'b0;
         s_d.unlk = sfm_pkg::ST_IDLE;
      end

      // set wins over a simultaneous software clear
      if (wdt_reset_event)
         s_d.syscfg[sfm_pkg::SYSCFG_WDR_BIT] = 1'b1;

      // boot start decision, taken once after reset release; zone size is fuse-only
      // with zone_enable set, a fully erased part reads blank at 0000h and so falls into the boot zone
      start_ok = zone_enable & (flash_byte0 == sfm_pkg::BLANK_BYTE); // [RULE17] [RULE18] [RULE16]
      if (!s_q.started)
      begin
         s_d.started = 1'b1;
         s_d.start_vld = 1'b1;
         s_d.start = start_ok ? zone_base(zone_cfg) : ADDR_W'(sfm_pkg::RESET_VECTOR); // [RULE17]
      end

      // engine request: enable bit gates the start; boot code uses the same path
      s_d.req.go = s_q.spctl[sfm_pkg::SPCTL_GO_BIT] & s_q.syscfg[sfm_pkg::SYSCFG_SPE_BIT]; // [RULE13] [RULE11]
      s_d.req.func = sfm_pkg::sfm_func_t'(s_q.spctl[1:0]); // [RULE21]
      s_d.req.addr = {s_q.spah, s_q.spal};
      s_d.req.data = s_q.spdat;
   end

////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         s_q <= '0; // [RULE7] [RULE8] [RULE9] [RULE10]
         s_q.p0 <= sfm_pkg::RST_PORT; // [RULE2]
         s_q.p1 <= sfm_pkg::RST_PORT;
         s_q.p2 <= sfm_pkg::RST_PORT;
         s_q.p3 <= sfm_pkg::RST_PORT3;
         s_q.p4 <= sfm_pkg::RST_PORT4; // [RULE3]
         s_q.sp <= sfm_pkg::RST_SP; // [RULE19]
         s_q.processor_status_word <= sfm_pkg::RST_STATW;
         s_q.serial_buffer <= sfm_pkg::RST_SERIAL_BUFFER; // [RULE4]
         s_q.syscfg <= sfm_pkg::RST_SYSCFG; // [RULE5]
         s_q.data_bank_select <= sfm_pkg::RST_DATA_BANK_SELECT; // [RULE6]
         s_q.tctl <= sfm_pkg::RST_TCTL;
         s_q.unlk <= sfm_pkg::ST_IDLE;
      end
      else
      begin
         s_q <= s_d;
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // the request bundle lives in the state register, so the engine sees flop outputs
   assign rdata = s_q.rdata;
   assign prog_req = s_q.req;
   assign core_hold = s_q.req.go;
   assign start_addr = s_q.start;
   assign start_valid = s_q.start_vld;
   assign sys_cfg = s_q.syscfg;
   assign pwr_ctl = s_q.pwr;
   assign wdt_ctl = s_q.wdt;
   assign bank_sel = s_q.data_bank_select;
endmodule // sfm_bank

// ===== verif/sfm_bank_monitor.sv
// concurrent checks on the register bank ports
`timescale 1ns/1ps
module sfm_bank_monitor #(
   parameter int ADDR_W = 16
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // core access
   input wire sfm_pkg::sfm_acc_t acc,
   input wire logic [7:0] rdata,
   // events and fuses
   input wire logic wdt_reset_event,
   input wire logic parity_in,
   input wire logic [2:0] zone_cfg,
   input wire logic zone_enable,
   input wire logic [7:0] flash_byte0,
   // flash engine
   input wire logic prog_done,
   input wire sfm_pkg::sfm_freq_t prog_req,
   input wire logic core_hold,
   // start select and control bits
   input wire logic [ADDR_W-1:0] start_addr,
   input wire logic start_valid,
   input wire logic [7:0] sys_cfg,
   input wire logic [7:0] pwr_ctl,
   input wire logic [7:0] wdt_ctl,
   input wire logic [7:0] bank_sel
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////////
   sequence s_done;
      prog_done ##1 1'b1;
   endsequence
   sequence s_boot_cond;
      start_valid && zone_enable && flash_byte0 == sfm_pkg::BLANK_BYTE;
   endsequence
   property p_rst_vals;
      $rose(resetn) |-> sys_cfg == sfm_pkg::RST_SYSCFG && bank_sel == sfm_pkg::RST_DATA_BANK_SELECT && pwr_ctl == 8'h00
         && wdt_ctl == 8'h00;
   endproperty
   property p_indirect;
      acc.rd && (!acc.direct || !acc.addr[7]) |=> rdata == 8'h00;
   endproperty
   property p_rd_quiet;
      !acc.rd |=> rdata == 8'h00;
   endproperty
   property p_wdr;
      wdt_reset_event |=> sys_cfg[7];
   endproperty
   property p_unused;
      (bank_sel & ~sfm_pkg::MSK_DATA_BANK_SELECT) == 8'h00 && (pwr_ctl & ~sfm_pkg::MSK_PWRCTL) == 8'h00
         && (wdt_ctl & ~sfm_pkg::MSK_WDCTL) == 8'h00;
   endproperty
   property p_go_enable;
      $rose(prog_req.go) |-> sys_cfg[2] && core_hold;
   endproperty
   property p_go_drop;
      s_done |-> ##1 !prog_req.go;
   endproperty
   property p_boot;
      s_boot_cond |-> start_addr == ADDR_W'({4'hf, ~zone_cfg, 9'h000});
   endproperty
   property p_normal;
      start_valid && (!zone_enable || flash_byte0 != sfm_pkg::BLANK_BYTE) |-> start_addr == '0;
   endproperty
   property p_start_rise;
      $rose(resetn) |-> ##[1:2] start_valid;
   endproperty
   property p_start_hold;
      start_valid |=> start_valid && $stable(start_addr);
   endproperty
   ////////////////////////////////////////////////////////////////////////////
   a_rst_vals: assert property (p_rst_vals) else $error("control register reset value wrong");
   a_indirect: assert property (p_indirect) else $error("indirect or low read returned data");
   a_rd_quiet: assert property (p_rd_quiet) else $error("read data without a read");
   a_wdr: assert property (p_wdr) else $error("watchdog flag not set");
   a_unused: assert property (p_unused) else $error("unused control bit set");
   a_go_enable: assert property (p_go_enable) else $error("start without enable or hold");
   a_go_drop: assert property (p_go_drop) else $error("start not cleared after done");
   a_boot: assert property (p_boot) else $error("boot start address wrong");
   a_normal: assert property (p_normal) else $error("normal start address wrong");
   a_start_rise: assert property (p_start_rise) else $error("start address not valid after reset");
   a_start_hold: assert property (p_start_hold) else $error("start address changed");
endmodule // sfm_bank_monitor

bind sfm_bank sfm_bank_monitor #(.ADDR_W(ADDR_W)) u_mon (.clk_sys(clk_sys), .resetn(resetn), .acc(acc),
   .rdata(rdata), .wdt_reset_event(wdt_reset_event), .parity_in(parity_in), .zone_cfg(zone_cfg),
   .zone_enable(zone_enable), .flash_byte0(flash_byte0), .prog_done(prog_done), .prog_req(prog_req),
   .core_hold(core_hold), .start_addr(start_addr), .start_valid(start_valid), .sys_cfg(sys_cfg),
   .pwr_ctl(pwr_ctl), .wdt_ctl(wdt_ctl), .bank_sel(bank_sel));

// ===== verif/sfm_flash_model.sv
// behavioural flash programming engine answering start requests
`timescale 1ns/1ps
module sfm_flash_model
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // request and completion
   input wire sfm_pkg::sfm_freq_t prog_req,
   input wire logic [3:0] lat,
   output logic prog_done
);
   logic [4:0] cnt_q;
   logic busy_q;
   // one done per request; stays busy until start drops so a held start is not served twice
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_q <= 5'h00;
         busy_q <= 1'b0;
         prog_done <= 1'b0;
      end
      else
      begin
         prog_done <= 1'b0;
         if (!busy_q)
         begin
            if (prog_req.go)
            begin
               busy_q <= 1'b1;
               cnt_q <= {1'b0, lat} + 5'h01;
            end
         end
         else
         begin
            if (cnt_q == 5'h01)
               prog_done <= 1'b1;
            if (cnt_q != 5'h00)
               cnt_q <= cnt_q - 5'h01;
            else if (!prog_req.go)
               busy_q <= 1'b0;
         end
      end
   end
endmodule // sfm_flash_model

// ===== verif/sfm_bank_tb.sv
// self-checking bench for the register bank and boot start select
`timescale 1ns/1ps
module sfm_bank_tb;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   sfm_pkg::sfm_acc_t acc = '0;
   logic wdt_reset_event = 1'b0;
   logic parity_in = 1'b1;
   logic [2:0] zone_cfg = 3'h7;
   logic zone_enable = 1'b1;
   logic [7:0] flash_byte0 = 8'hff;
   logic [3:0] lat = 4'h1;
   logic prog_done, core_hold, start_valid;
   sfm_pkg::sfm_freq_t prog_req;
   logic [7:0] rdata, sys_cfg, pwr_ctl, wdt_ctl, bank_sel;
   logic [15:0] start_addr;
   int failures = 0;
   int checked = 0;
   int cycles = 0;
   int i, n;
   // {addr, expected, mask}
   logic [23:0] rst_tab [0:22] = '{24'h80ffff, 24'h8107ff, 24'h8200ff, 24'h8601ff, 24'h8700ff, 24'h8802ff,
      24'h90ffff, 24'h997fff, 24'h9f00ff, 24'ha0ffff, 24'ha400ff, 24'ha500ff, 24'ha600ff, 24'ha700ff,
      24'hac00ff, 24'hb0fbff, 24'hbf0aff, 24'hd001ff, 24'hd80f0f, 24'hf400ff, 24'hf500ff, 24'hf600ff, 24'hf700ff};
   // {addr, write data, expected}
   logic [23:0] wr_tab [0:7] = '{24'h86ff8f, 24'h87ff8f, 24'h9fffa7, 24'ha4ffff, 24'hacffff, 24'hd0fffd,
      24'hf7ff03, 24'h85ff03};
   // {enable, cfg, byte at 0000h, start address}
   logic [31:0] boot_tab [0:4] = '{32'h17fff000, 32'h10fffe00, 32'h13fff800, 32'h17000000, 32'h07ff0000};
   always #25 clk_sys = ~clk_sys;
   sfm_bank DUT (.clk_sys(clk_sys), .resetn(resetn), .acc(acc), .rdata(rdata), .wdt_reset_event(wdt_reset_event),
      .parity_in(parity_in), .zone_cfg(zone_cfg), .zone_enable(zone_enable), .flash_byte0(flash_byte0),
      .prog_done(prog_done), .prog_req(prog_req), .core_hold(core_hold), .start_addr(start_addr),
      .start_valid(start_valid), .sys_cfg(sys_cfg), .pwr_ctl(pwr_ctl), .wdt_ctl(wdt_ctl), .bank_sel(bank_sel));
   sfm_flash_model u_flash (.clk_sys(clk_sys), .resetn(resetn), .prog_req(prog_req), .lat(lat),
      .prog_done(prog_done));
   ////////////////////////////////////////////////////////////////////////////
   task stop_test;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d, input logic dir);
      @(posedge clk_sys);
      acc <= '{wr: 1'b1, rd: 1'b0, direct: dir, addr: a, wdata: d};
      @(posedge clk_sys);
      acc.wr <= 1'b0;
   endtask
   // read data is registered: look one step after the edge that takes the read
   task rdc(input string nm, input logic [7:0] a, input logic dir, input logic [7:0] e, input logic [7:0] m);
      @(posedge clk_sys);
      acc <= '{wr: 1'b0, rd: 1'b1, direct: dir, addr: a, wdata: 8'h00};
      @(posedge clk_sys);
      acc.rd <= 1'b0;
      #1 chk8(nm, e & m, rdata & m);
   endtask
   // programmer side: zone enable, zone size and byte at 0000h are fixed only while reset is held
   task do_reset(input logic en, input logic [2:0] cfg, input logic [7:0] b0);
      @(posedge clk_sys);
      resetn <= 1'b0;
      @(posedge clk_sys);
      zone_enable <= en;
      zone_cfg <= cfg;
      flash_byte0 <= b0;
      repeat (20) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (3) @(posedge clk_sys);
   endtask
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles > 20000)
      begin
         failures++;
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      do_reset(1'b1, 3'h7, 8'hff);
      for (i = 0; i < 23; i++)
         rdc("reset value", rst_tab[i][23:16], 1'b1, rst_tab[i][15:8], rst_tab[i][7:0]);
      rdc("indirect read", 8'h80, 1'b0, 8'h00, 8'hff);
      rdc("low address read", 8'h40, 1'b1, 8'h00, 8'hff);
      rdc("unmapped read", 8'h84, 1'b1, 8'h00, 8'hff);
      wr(8'h81, 8'h55, 1'b0);
      rdc("indirect write", 8'h81, 1'b1, 8'h07, 8'hff);
      for (i = 0; i < 8; i++)
      begin
         wr(wr_tab[i][23:16], wr_tab[i][15:8], 1'b1);
         rdc("write mask", wr_tab[i][23:16], 1'b1, wr_tab[i][7:0], 8'hff);
      end
      @(posedge clk_sys);
      wdt_reset_event <= 1'b1;
      @(posedge clk_sys);
      wdt_reset_event <= 1'b0;
      rdc("watchdog flag", 8'hbf, 1'b1, 8'h80, 8'h80);
      // every function code, with the engine answering ever more slowly
      for (i = 0; i < 4; i++)
      begin
         lat <= 4'(1 + 4 * i);
         wr(8'hf4, 8'h12, 1'b1);
         wr(8'hf5, 8'h34, 1'b1);
         wr(8'hbf, 8'h04, 1'b1);
         wr(8'hf6, sfm_pkg::UNLOCK_A, 1'b1);
         wr(8'hf6, sfm_pkg::UNLOCK_B, 1'b1);
         wr(8'hf6, sfm_pkg::UNLOCK_A, 1'b1);
         wr(8'hf7, {6'h20, i[1:0]}, 1'b1);
         n = 0;
         while (prog_req.go !== 1'b1 && n < 10)
         begin
            @(posedge clk_sys);
            #1 n++;
         end
         chk8("request function", {6'h00, i[1:0]}, {6'h00, prog_req.func});
         chk16("request address", 16'h1234, prog_req.addr);
         chk8("request data", sfm_pkg::UNLOCK_A, prog_req.data);
         chk8("core hold", 8'h01, {7'h00, core_hold});
         n = 0;
         while (prog_req.go !== 1'b0 && n < 40)
         begin
            @(posedge clk_sys);
            #1 n++;
         end
         chk8("request released", 8'h00, {7'h00, prog_req.go});
         rdc("control after done", 8'hf7, 1'b1, {6'h00, i[1:0]}, 8'h83);
      end
      wr(8'hf7, 8'h80, 1'b1);
      rdc("start relocked", 8'hf7, 1'b1, 8'h00, 8'h80);
      for (i = 0; i < 5; i++)
      begin
         do_reset(boot_tab[i][28], boot_tab[i][26:24], boot_tab[i][23:16]);
         chk8("start valid", 8'h01, {7'h00, start_valid});
         chk16("start address", boot_tab[i][15:0], start_addr);
      end
      stop_test();
   end
endmodule // sfm_bank_tb
